//--- include/bbi_pkg.sv
// Shared constants and types for the backlight bias two-wire register slave
package bbi_pkg;

  // ==========================================================
  // Bus address and register offsets
  localparam logic [6:0] SLAVE_ADDR = 7'h11;
  localparam logic [7:0] REG_REV = 8'h01;
  localparam logic [7:0] REG_BL_CFG1 = 8'h02;
  localparam logic [7:0] REG_BL_CFG2 = 8'h03;
  localparam logic [7:0] REG_BRT_LO = 8'h04;
  localparam logic [7:0] REG_BRT_HI = 8'h05;
  localparam logic [7:0] REG_BACKLIGHT_ENABLE_BIT = 8'h08;
  localparam logic [7:0] REG_BIAS1 = 8'h09;
  localparam logic [7:0] REG_BIAS2 = 8'h0a;
  localparam logic [7:0] REG_BOOST = 8'h0c;
  localparam logic [7:0] REG_VPOS = 8'h0d;
  localparam logic [7:0] REG_VNEG = 8'h0e;
  localparam logic [7:0] REG_FLAGS = 8'h0f;
  localparam logic [7:0] REG_BL_OPT1 = 8'h10;
  localparam logic [7:0] REG_LAST_RW = 8'h11;
  localparam logic [7:0] REG_CODE_LO = 8'h12;
  localparam logic [7:0] REG_CODE_HI = 8'h13;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BL_CFG1 = 8'h28;
  localparam logic [7:0] RST_BL_CFG2 = 8'h8d;
  localparam logic [7:0] RST_BRT_LO = 8'h07;
  localparam logic [7:0] RST_BRT_HI = 8'hff;
  localparam logic [7:0] RST_BIAS1 = 8'h18;
  localparam logic [7:0] RST_BIAS2 = 8'h11;
  localparam logic [7:0] RST_BOOST = 8'h28;
  localparam logic [7:0] RST_VPOS = 8'h1e;
  localparam logic [7:0] RST_VNEG = 8'h1c;
  localparam logic [7:0] RST_OPT1 = 8'h06;
  localparam logic [7:0] RST_OPT2 = 8'h35;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ==========================================================
  // Field positions
  localparam int F_OVP_HI = 7;
  localparam int F_OVP_LO = 5;
  localparam int F_OVP_RESP = 4;
  localparam int F_MAP = 3;
  localparam int F_POL = 2;
  localparam int F_RAMP = 1;
  localparam int F_PULSE_EN = 0;
  localparam int F_BOOST = 7;
  localparam int F_TTIME_HI = 6;
  localparam int F_TTIME_LO = 3;
  localparam int F_SAMPLE = 2;
  localparam int F_HYST_HI = 1;
  localparam int F_HYST_LO = 0;
  localparam int F_FAST = 0;
  localparam int F_SWRESET = 7;
  localparam int F_BACKLIGHT_ENABLE_BIT = 4;
  localparam int F_SINK2 = 1;
  localparam int F_SINK1 = 0;
  localparam logic [2:0] OVP_TOP_CODE = 3'h3;

  // ==========================================================
  // Enumerations
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_RX = 5'b0_0010,
    ST_ACK = 5'b0_0100,
    ST_TX = 5'b0_1000,
    ST_MACK = 5'b1_0000
  } bbi_state_t;

  typedef enum logic [2:0] {
    KIND_ADDR = 3'b001,
    KIND_PTR = 3'b010,
    KIND_DATA = 3'b100
  } bbi_kind_t;

  typedef enum logic [1:0] {
    SMP_1M = 2'h0,
    SMP_4M = 2'h1,
    SMP_24M = 2'h2
  } bbi_sample_t;

  // Decoded backlight controls handed to the analog side
  typedef struct packed {
    logic [1:0] ovp_sel;
    logic ovp_shutdown;
    logic map_linear;
    logic pulse_active_low;
    logic pulse_enable;
    logic pulse_ramp;
    logic boost_rate_high;
    logic [3:0] transition_time;
    bbi_sample_t sample_mode;
    logic [1:0] hysteresis;
    logic backlight_enable;
    logic sink_two_enable;
    logic sink_one_enable;
  } bbi_bl_cfg_t;

endpackage : bbi_pkg

//--- design/bbi_i2c_regs.sv
// Two-wire slave and register bank of the backlight bias device
`timescale 1ns/10ps

module bbi_i2c_regs #(
  parameter logic [6:0] DEV_ADDR = bbi_pkg::SLAVE_ADDR,
  parameter logic [2:0] REV_FIELD = 3'h2,  // Arbitrary revision value
  parameter logic [1:0] MAKER_FIELD = 2'h2  // Arbitrary maker value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Status from the analog side
  input wire logic [7:0] fault_flags,
  input wire logic [15:0] pulse_code,
  // Decoded controls
  output bbi_pkg::bbi_bl_cfg_t bl_cfg_r,
  output logic bus_busy_r
);

  // ==========================================================
  // Elaboration checks
  generate
    if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77) begin : g_bad_addr
      $error("Slave address lies in a reserved range");
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers and bus condition detectors
  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r;
  logic scl_rise, scl_fall, start_det, stop_det;

  // Two stages per pin, third stage for edge finding
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  // Edge and condition decode
  assign scl_rise = scl_s2_r & ~scl_s3_r;
  assign scl_fall = ~scl_s2_r & scl_s3_r;
  assign start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign stop_det = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

  // ==========================================================
  // Transfer state machine
  bbi_pkg::bbi_state_t state_r;
  bbi_pkg::bbi_kind_t kind_r;
  logic [3:0] cnt_r;
  logic [7:0] shreg_r;
  logic [7:0] ptr_r;
  logic rw_r;
  logic acked_r;
  logic oe_r;
  logic [7:0] rd_data;
  logic wr_en;
  logic byte_done;

  // A full byte has been clocked in and the ninth clock begins
  assign byte_done = (state_r == bbi_pkg::ST_RX) && scl_fall && (cnt_r == 4'h8);
  assign wr_en = byte_done && (kind_r == bbi_pkg::KIND_DATA);

  // Sequencing of bytes, acknowledges and the register pointer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= bbi_pkg::ST_IDLE;
      kind_r <= bbi_pkg::KIND_ADDR;
      cnt_r <= 4'h0;
      shreg_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      acked_r <= 1'b0;
      oe_r <= 1'b0;
      bus_busy_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= bbi_pkg::ST_IDLE;
      oe_r <= 1'b0;
      bus_busy_r <= 1'b0;
    end else if (start_det) begin
      state_r <= bbi_pkg::ST_RX;
      kind_r <= bbi_pkg::KIND_ADDR;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
      bus_busy_r <= 1'b1;
    end else begin
      unique case (state_r)
        bbi_pkg::ST_IDLE: begin
          oe_r <= 1'b0;
        end
        bbi_pkg::ST_RX: begin
          if (scl_rise) begin
            shreg_r <= {shreg_r[6:0], sda_s2_r};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_done) begin
            if (kind_r == bbi_pkg::KIND_ADDR) begin
              if (shreg_r[7:1] == DEV_ADDR) begin
                rw_r <= shreg_r[0];
                state_r <= bbi_pkg::ST_ACK;
                oe_r <= 1'b1;
              end else begin
                state_r <= bbi_pkg::ST_IDLE;
              end
            end else begin
              state_r <= bbi_pkg::ST_ACK;
              oe_r <= 1'b1;
              if (kind_r == bbi_pkg::KIND_PTR) begin
                ptr_r <= shreg_r;
              end
            end
          end
        end
        bbi_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            if (kind_r == bbi_pkg::KIND_ADDR && rw_r) begin
              state_r <= bbi_pkg::ST_TX;
              shreg_r <= rd_data;
              oe_r <= ~rd_data[7];
            end else begin
              state_r <= bbi_pkg::ST_RX;
              oe_r <= 1'b0;
              if (kind_r == bbi_pkg::KIND_ADDR) begin
                kind_r <= bbi_pkg::KIND_PTR;
              end else if (kind_r == bbi_pkg::KIND_PTR) begin
                kind_r <= bbi_pkg::KIND_DATA;
              end else begin
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
        end
        bbi_pkg::ST_TX: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              state_r <= bbi_pkg::ST_MACK;
              oe_r <= 1'b0;
            end else begin
              shreg_r <= {shreg_r[6:0], 1'b0};
              oe_r <= ~shreg_r[6];
            end
          end
        end
        bbi_pkg::ST_MACK: begin
          if (scl_rise) begin
            acked_r <= ~sda_s2_r;
            if (!sda_s2_r) begin
              ptr_r <= ptr_r + 8'h01;
            end
          end else if (scl_fall) begin
            cnt_r <= 4'h0;
            if (acked_r) begin
              state_r <= bbi_pkg::ST_TX;
              shreg_r <= rd_data;
              oe_r <= ~rd_data[7];
            end else begin
              state_r <= bbi_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Open-drain data pin: only ever pulls low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= oe_r;
    end
  end

  // ==========================================================
  // Register file
  logic [7:0] rf_r [bbi_pkg::REG_BL_CFG1:bbi_pkg::REG_LAST_RW];
  logic swr_pend_r;

  // Default of each stored register
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      bbi_pkg::REG_BL_CFG1: rst_val = bbi_pkg::RST_BL_CFG1;
      bbi_pkg::REG_BL_CFG2: rst_val = bbi_pkg::RST_BL_CFG2;
      bbi_pkg::REG_BRT_LO: rst_val = bbi_pkg::RST_BRT_LO;
      bbi_pkg::REG_BRT_HI: rst_val = bbi_pkg::RST_BRT_HI;
      bbi_pkg::REG_BIAS1: rst_val = bbi_pkg::RST_BIAS1;
      bbi_pkg::REG_BIAS2: rst_val = bbi_pkg::RST_BIAS2;
      bbi_pkg::REG_BOOST: rst_val = bbi_pkg::RST_BOOST;
      bbi_pkg::REG_VPOS: rst_val = bbi_pkg::RST_VPOS;
      bbi_pkg::REG_VNEG: rst_val = bbi_pkg::RST_VNEG;
      bbi_pkg::REG_BL_OPT1: rst_val = bbi_pkg::RST_OPT1;
      bbi_pkg::REG_LAST_RW: rst_val = bbi_pkg::RST_OPT2;
      default: rst_val = bbi_pkg::RST_ZERO;
    endcase
  endfunction : rst_val

  // Writable only inside the stored range, flags excluded
  function automatic logic writable(input logic [7:0] a);
    writable = (a >= bbi_pkg::REG_BL_CFG1) && (a <= bbi_pkg::REG_LAST_RW)
               && (a != bbi_pkg::REG_FLAGS);
  endfunction : writable

  // Software reset request from the enable register top bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      swr_pend_r <= 1'b0;
    end else begin
      swr_pend_r <= wr_en && (ptr_r == bbi_pkg::REG_BACKLIGHT_ENABLE_BIT) && shreg_r[bbi_pkg::F_SWRESET];
    end
  end

  // Storage; reset bit self-clears because it is never stored
  always_ff @(posedge clk_sys) begin
    if (sys_rst || swr_pend_r) begin
      for (int i = bbi_pkg::REG_BL_CFG1; i <= bbi_pkg::REG_LAST_RW; i++) begin
        rf_r[i] <= rst_val(8'(i));
      end
    end else if (wr_en && writable(ptr_r)) begin
      if (ptr_r == bbi_pkg::REG_BACKLIGHT_ENABLE_BIT) begin
        rf_r[ptr_r] <= {1'b0, shreg_r[6:0]};
      end else begin
        rf_r[ptr_r] <= shreg_r;
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_data = 8'h00;
    if (ptr_r == bbi_pkg::REG_REV) begin
      rd_data = {REV_FIELD, 3'h0, MAKER_FIELD};
    end else if (ptr_r == bbi_pkg::REG_FLAGS) begin
      rd_data = fault_flags;
    end else if (ptr_r == bbi_pkg::REG_CODE_LO) begin
      rd_data = pulse_code[7:0];
    end else if (ptr_r == bbi_pkg::REG_CODE_HI) begin
      rd_data = pulse_code[15:8];
    end else if (writable(ptr_r)) begin
      rd_data = rf_r[ptr_r];
    end
  end

  // ==========================================================
  // Decoded backlight controls
  bbi_pkg::bbi_bl_cfg_t cfg_nxt;
  logic [7:0] c1, c2, en;

  // Field extraction and level saturation
  always_comb begin
    c1 = rf_r[bbi_pkg::REG_BL_CFG1];
    c2 = rf_r[bbi_pkg::REG_BL_CFG2];
    en = rf_r[bbi_pkg::REG_BACKLIGHT_ENABLE_BIT];
    if (c1[bbi_pkg::F_OVP_HI:bbi_pkg::F_OVP_LO] > bbi_pkg::OVP_TOP_CODE) begin
      cfg_nxt.ovp_sel = 2'h3;
    end else begin
      cfg_nxt.ovp_sel = c1[bbi_pkg::F_OVP_LO+1:bbi_pkg::F_OVP_LO];
    end
    cfg_nxt.ovp_shutdown = c1[bbi_pkg::F_OVP_RESP];
    cfg_nxt.map_linear = c1[bbi_pkg::F_MAP];
    cfg_nxt.pulse_active_low = c1[bbi_pkg::F_POL];
    cfg_nxt.pulse_enable = c1[bbi_pkg::F_PULSE_EN];
    cfg_nxt.pulse_ramp = c1[bbi_pkg::F_RAMP];
    cfg_nxt.boost_rate_high = c2[bbi_pkg::F_BOOST];
    cfg_nxt.transition_time = c2[bbi_pkg::F_TTIME_HI:bbi_pkg::F_TTIME_LO];
    cfg_nxt.hysteresis = c2[bbi_pkg::F_HYST_HI:bbi_pkg::F_HYST_LO];
    if (rf_r[bbi_pkg::REG_BL_OPT1][bbi_pkg::F_FAST]) begin
      cfg_nxt.sample_mode = bbi_pkg::SMP_24M;
    end else if (c2[bbi_pkg::F_SAMPLE]) begin
      cfg_nxt.sample_mode = bbi_pkg::SMP_4M;
    end else begin
      cfg_nxt.sample_mode = bbi_pkg::SMP_1M;
    end
    cfg_nxt.backlight_enable = en[bbi_pkg::F_BACKLIGHT_ENABLE_BIT];
    cfg_nxt.sink_two_enable = en[bbi_pkg::F_SINK2];
    cfg_nxt.sink_one_enable = en[bbi_pkg::F_SINK1];
  end

  // Registered control outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bl_cfg_r <= '0;
    end else begin
      bl_cfg_r <= cfg_nxt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_start_busy: assert property (start_det |=> bus_busy_r && state_r == bbi_pkg::ST_RX)
    else $error("Start did not begin a transfer");
  a_stop_idle: assert property (stop_det |=> !bus_busy_r && state_r == bbi_pkg::ST_IDLE)
    else $error("Stop did not end the transfer");
  a_ack_drive: assert property (state_r == bbi_pkg::ST_ACK && !start_det && !stop_det
    |=> sda_oe)
    else $error("Acknowledge not driven low");
  a_addr_match: assert property (byte_done && kind_r == bbi_pkg::KIND_ADDR
    && shreg_r[7:1] != DEV_ADDR && !start_det && !stop_det
    |=> state_r == bbi_pkg::ST_IDLE ##1 !sda_oe)
    else $error("Foreign address acknowledged");
  a_dir_read: assert property (state_r == bbi_pkg::ST_ACK && scl_fall && rw_r
    && kind_r == bbi_pkg::KIND_ADDR && !start_det && !stop_det
    |=> state_r == bbi_pkg::ST_TX && shreg_r == $past(rd_data))
    else $error("Read direction did not start transmit");
  a_wr_ptr_step: assert property (state_r == bbi_pkg::ST_ACK && scl_fall
    && kind_r == bbi_pkg::KIND_DATA && !start_det && !stop_det
    |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("Write pointer did not advance");
  a_rd_ptr_step: assert property (state_r == bbi_pkg::ST_MACK && scl_rise && !sda_s2_r
    && !start_det && !stop_det |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("Read pointer did not advance");
  a_reset_dflt: assert property (disable iff (1'b0) sys_rst |=>
    rf_r[bbi_pkg::REG_BL_CFG1] == bbi_pkg::RST_BL_CFG1
    && rf_r[bbi_pkg::REG_BL_CFG2] == bbi_pkg::RST_BL_CFG2)
    else $error("Register default lost after reset");
  a_ro_const: assert property (wr_en && !writable(ptr_r)
    |=> rd_data == $past(rd_data))
    else $error("Read-only register changed");
  a_ovp_sat: assert property (rf_r[bbi_pkg::REG_BL_CFG1][7] && $stable(rf_r[bbi_pkg::REG_BL_CFG1])
    |=> bl_cfg_r.ovp_sel == 2'h3)
    else $error("Overvoltage level not saturated");
  a_fast_smp: assert property (rf_r[bbi_pkg::REG_BL_OPT1][0]
    && $stable(rf_r[bbi_pkg::REG_BL_OPT1]) |=> bl_cfg_r.sample_mode == bbi_pkg::SMP_24M)
    else $error("Fast sampler not selected");
  a_unmapped_zero: assert property (ptr_r > bbi_pkg::REG_CODE_HI |-> rd_data == 8'h00)
    else $error("Unmapped read not zero");

  c_write_data: cover property (wr_en ##[1:200] stop_det);
  c_read_next: cover property (state_r == bbi_pkg::ST_MACK && acked_r && scl_fall);
  c_soft_reset: cover property (swr_pend_r);
  c_foreign_addr: cover property (byte_done && kind_r == bbi_pkg::KIND_ADDR
    && shreg_r[7:1] != DEV_ADDR);

endmodule : bbi_i2c_regs

//--- test/bbi_master_model.sv
// Two-wire bus master model that drives the slave from the far side
`timescale 1ns/10ps

module bbi_master_model (
  // Clock
  input wire logic clk_sys,
  // Bus lines: clock out, pull-down enable out, resolved data in
  output logic scl,
  output logic m_pull,
  input wire logic sda
);

  // ==========================================================
  // Timing helper, all changes land on the falling clk_sys edge
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt

  // Start or repeated start; long low phase lets the slave release first
  task automatic start_c;
    wt(1);
    m_pull = 1'b0;
    wt(8);
    scl = 1'b1;
    wt(4);
    m_pull = 1'b1;
    wt(4);
    scl = 1'b0;
  endtask : start_c

  // Stop ends any transfer
  task automatic stop_c;
    wt(1);
    m_pull = 1'b1;
    wt(8);
    scl = 1'b1;
    wt(4);
    m_pull = 1'b0;
    wt(8);
  endtask : stop_c

  // One clock: data set after a hold cycle, sampled at end of high phase
  task automatic bit_c(input logic b, output logic s);
    wt(1);
    m_pull = ~b;
    wt(3);
    scl = 1'b1;
    wt(4);
    s = sda;
    scl = 1'b0;
  endtask : bit_c

  // Byte out MSB first, then ninth clock with the line released
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    wt(4);
    for (int i = 7; i >= 0; i--) begin
      bit_c(d[i], s);
    end
    bit_c(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  // Byte in; last byte gets a released ninth clock
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    wt(4);
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, d[i]);
    end
    bit_c(last, s);
  endtask : rd_byte

  // Idle bus, both lines released
  initial begin
    scl = 1'b1;
    m_pull = 1'b0;
  end

endmodule : bbi_master_model

//--- test/tb_top.sv
// Self-checking bench for the backlight bias two-wire register slave
`timescale 1ns/10ps

module tb_top;

  // ==========================================================
  // Signals
  logic clk_sys, sys_rst, scl, m_pull, sda_out, sda_oe, bus_busy_r;
  logic [7:0] fault_flags;
  logic [15:0] pulse_code;
  wire logic sda;
  bbi_pkg::bbi_bl_cfg_t bl_cfg_r, exp_cfg;
  int err_total, n_tests, seed;
  logic [7:0] mdl [0:255];
  logic [7:0] wq [$];

  // Open-drain wire with pull-up
  assign sda = ~(sda_oe | m_pull);

  // Revision and maker fields below are arbitrary values
  bbi_i2c_regs #(.DEV_ADDR(bbi_pkg::SLAVE_ADDR), .REV_FIELD(3'h5), .MAKER_FIELD(2'h2)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .fault_flags(fault_flags), .pulse_code(pulse_code),
    .bl_cfg_r(bl_cfg_r), .bus_busy_r(bus_busy_r));

  bbi_master_model m (.clk_sys(clk_sys), .scl(scl), .m_pull(m_pull), .sda(sda));

  // ==========================================================
  // Reference model
  function automatic void mdl_rst;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h02] = 8'h28;
    mdl[8'h03] = 8'h8d;
    mdl[8'h04] = 8'h07;
    mdl[8'h05] = 8'hff;
    mdl[8'h09] = 8'h18;
    mdl[8'h0a] = 8'h11;
    mdl[8'h0c] = 8'h28;
    mdl[8'h0d] = 8'h1e;
    mdl[8'h0e] = 8'h1c;
    mdl[8'h10] = 8'h06;
    mdl[8'h11] = 8'h35;
  endfunction : mdl_rst

  function automatic void mdl_wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h01 || a == 8'h0f || a == 8'h12 || a == 8'h13 || a > 8'h13) return;
    if (a == 8'h08 && d[7]) mdl_rst();
    else mdl[a] = d;
  endfunction : mdl_wr

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h01: return {3'h5, 3'h0, 2'h2};
      8'h0f: return fault_flags;
      8'h12: return pulse_code[7:0];
      8'h13: return pulse_code[15:8];
      default: return (a > 8'h13) ? 8'h00 : mdl[a];
    endcase
  endfunction : exp_rd

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Pointer then queued bytes; a foreign address must be ignored
  task automatic wr_regs(input logic [7:0] p, input logic [6:0] da);
    logic ack, hit;
    hit = (da == bbi_pkg::SLAVE_ADDR);
    m.start_c();
    m.wr_byte({da, 1'b0}, ack);
    chk("addr ack", 32'(hit), 32'(ack));
    chk("busy", 32'h1, 32'(bus_busy_r));
    m.wr_byte(p, ack);
    chk("ptr ack", 32'(hit), 32'(ack));
    foreach (wq[i]) begin
      m.wr_byte(wq[i], ack);
      chk("data ack", 32'(hit), 32'(ack));
      if (hit) mdl_wr(p, wq[i]);
      p++;
    end
    m.stop_c();
    chk("idle", 32'h0, 32'(bus_busy_r));
  endtask : wr_regs

  // Pointer write, repeated start, n bytes read
  task automatic rd_regs(input logic [7:0] p, input int n);
    logic ack;
    logic [7:0] d;
    m.start_c();
    m.wr_byte({bbi_pkg::SLAVE_ADDR, 1'b0}, ack);
    m.wr_byte(p, ack);
    m.start_c();
    m.wr_byte({bbi_pkg::SLAVE_ADDR, 1'b1}, ack);
    chk("read ack", 32'h1, 32'(ack));
    for (int i = 0; i < n; i++) begin
      m.rd_byte(i == n - 1, d);
      chk($sformatf("reg %h", p), 32'(exp_rd(p)), 32'(d));
      p++;
    end
    chk("released", 32'h0, 32'(sda_oe));
    chk("out level", 32'h0, 32'(sda_out));
    m.stop_c();
  endtask : rd_regs

  // Decoded controls against the model registers
  task automatic cfg_chk;
    logic [7:0] c1, c2, en, o1;
    c1 = mdl[8'h02];
    c2 = mdl[8'h03];
    en = mdl[8'h08];
    o1 = mdl[8'h10];
    exp_cfg.ovp_sel = (c1[7:5] > 3'h3) ? 2'h3 : c1[6:5];
    exp_cfg.ovp_shutdown = c1[4];
    exp_cfg.map_linear = c1[3];
    exp_cfg.pulse_active_low = c1[2];
    exp_cfg.pulse_enable = c1[0];
    exp_cfg.pulse_ramp = c1[1];
    exp_cfg.boost_rate_high = c2[7];
    exp_cfg.transition_time = c2[6:3];
    exp_cfg.sample_mode = o1[0] ? bbi_pkg::SMP_24M : (c2[2] ? bbi_pkg::SMP_4M : bbi_pkg::SMP_1M);
    exp_cfg.hysteresis = c2[1:0];
    exp_cfg.backlight_enable = en[4];
    exp_cfg.sink_two_enable = en[1];
    exp_cfg.sink_one_enable = en[0];
    chk("bl cfg", 32'(exp_cfg), 32'(bl_cfg_r));
  endtask : cfg_chk

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    err_total++;
    $display("BAD watchdog expected end seen hang");
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 38914;
    err_total = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    fault_flags = 8'($random(seed));
    pulse_code = 16'($random(seed));
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    mdl_rst();
    repeat (4) @(negedge clk_sys);
    rd_regs(8'h01, 21);
    cfg_chk();
    $display("test defaults done");
    // Burst across read-only and unmapped places; enables kept off
    wq = {};
    for (int a = 1; a <= 20; a++) begin
      wq.push_back((a == 8) ? 8'($random(seed)) & 8'h60 : 8'($random(seed)));
    end
    wr_regs(8'h01, bbi_pkg::SLAVE_ADDR);
    rd_regs(8'h01, 21);
    cfg_chk();
    $display("test burst done");
    // Every overvoltage code with random companions and sampler overrides
    for (int c = 0; c < 8; c++) begin
      wq = {{3'(c), 5'($random(seed))}, 8'($random(seed))};
      wr_regs(8'h02, bbi_pkg::SLAVE_ADDR);
      wq = {8'($random(seed))};
      wr_regs(8'h10, bbi_pkg::SLAVE_ADDR);
      cfg_chk();
    end
    // Enables last, once the pulse settings are in place
    wq = {8'($random(seed)) & 8'h13};
    wr_regs(8'h08, bbi_pkg::SLAVE_ADDR);
    cfg_chk();
    $display("test decode done");
    // Foreign address leaves registers alone
    wq = {8'h5a, 8'ha5};
    wr_regs(8'h04, bbi_pkg::SLAVE_ADDR ^ 7'h01);
    rd_regs(8'h04, 2);
    $display("test foreign address done");
    // Software reset through the enable register
    fault_flags = 8'($random(seed));
    pulse_code = 16'($random(seed));
    wq = {8'h80};
    wr_regs(8'h08, bbi_pkg::SLAVE_ADDR);
    repeat (4) @(negedge clk_sys);
    rd_regs(8'h01, 19);
    cfg_chk();
    $display("test soft reset done");
    // Hardware reset in mid-run after changes
    wq = {8'($random(seed)), 8'($random(seed))};
    wr_regs(8'h09, bbi_pkg::SLAVE_ADDR);
    sys_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    mdl_rst();
    repeat (4) @(negedge clk_sys);
    rd_regs(8'h01, 19);
    cfg_chk();
    $display("test hard reset done");
    end_sim();
  end

endmodule : tb_top
